// >>> include/csr_defines.vh
// Constants for the channel setup register block: register offsets,
// field positions, reset values and the arbitrary identity code.
// Assumes an 8-bit word address and 16-bit register data.
`ifndef CSR_DEFINES_VH
`define CSR_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CSR_ADDR_IDENTITY     8'h07
`define CSR_ADDR_CHAN_ZERO    8'h10
`define CSR_ADDR_SEQ_STATUS   8'h7F

// ----------------------------------------------------------------
// Channel configuration fields
// ----------------------------------------------------------------
`define CSR_CH_ENABLE_BIT     15
`define CSR_CH_SETUP_MSB      14
`define CSR_CH_SETUP_LSB      12
`define CSR_CH_INPUT_MSB      9
`define CSR_CH_INPUT_LSB      0
`define CSR_CH_WRITE_MASK     16'hF3FF
`define CSR_CH_ZERO_RESET     16'h8001

// ----------------------------------------------------------------
// Sequencer status fields
// ----------------------------------------------------------------
`define CSR_ST_RUNNING_BIT    15
`define CSR_ST_SETUP_MSB      14
`define CSR_ST_SETUP_LSB      12
`define CSR_ST_CHAN_LSB       0

// ----------------------------------------------------------------
// Identity
// ----------------------------------------------------------------
// The value is arbitrary and neutral; the real part code is set per product.
`define CSR_IDENTITY_DEFAULT  16'h5A5A

`endif

// >>> core/csr_sequencer.v
// Channel sequencer: walks round the enabled channels, one conversion each.
// Assumes conversionDone is a one-cycle pulse from the modulator/filter.
`timescale 1ns/1ps

module csr_sequencer #(
	parameter NUM_CH  = 16,
	parameter CH_BITS = 4
) (
	// Clock and reset
	input  wire               clk,
	input  wire               rst_n,
	// Channel enables and conversion events
	input  wire [NUM_CH-1:0]  chanEnable,
	input  wire               conversionDone,
	// Sequencer state
	output reg  [CH_BITS-1:0] activeChannel,
	output reg                running,
	output reg                switched
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam IDLE = 1'b0;
	localparam RUN  = 1'b1;

	reg               state;
	reg [CH_BITS-1:0] nextFromCurrent;
	reg [CH_BITS-1:0] nextFromTop;

	// First enabled channel after cur, wrapping; cur itself if it is the only one.
	function [CH_BITS-1:0] nextEnabled;
		input [NUM_CH-1:0]  en;
		input [CH_BITS-1:0] cur;
		integer             k;
		integer             idx;
		reg                 found;
		begin
			found       = 1'b0;
			nextEnabled = cur;
			for (k = 1; k <= NUM_CH; k = k + 1) begin
				idx = (cur + k) % NUM_CH;
				if (!found && en[idx]) begin
					found       = 1'b1;
					nextEnabled = idx[CH_BITS-1:0];
				end
			end
		end
	endfunction

	always @* begin
		nextFromCurrent = nextEnabled(chanEnable, activeChannel);
		nextFromTop     = nextEnabled(chanEnable, NUM_CH[CH_BITS-1:0] - 1'b1);
	end

	// ----------------------------------------------------------------
	// Stepping
	// ----------------------------------------------------------------
	// A channel disabled while it converts is left at once rather than
	// finishing, so software never waits on a channel it switched off.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state         <= IDLE;
			activeChannel <= {CH_BITS{1'b0}};
			running       <= 1'b0;
			switched      <= 1'b0;
		end else begin
			switched <= 1'b0;
			case (state)
				IDLE: begin
					if (|chanEnable) begin
						activeChannel <= nextFromTop;
						state         <= RUN;
						running       <= 1'b1;
						switched      <= 1'b1;
					end
				end
				RUN: begin
					if (~|chanEnable) begin
						state   <= IDLE;
						running <= 1'b0;
					end else if (conversionDone || !chanEnable[activeChannel]) begin
						activeChannel <= nextFromCurrent;
						switched      <= 1'b1;
					end
				end
				default: begin
					state   <= IDLE;
					running <= 1'b0;
				end
			endcase
		end
	end

endmodule

// >>> core/csr_channel_regs.v
// Identity word, first channel configuration register, and the logic that
// turns the enabled channels into the setup and input pair now converting.
// Assumes the serial interface presents a plain strobe port on clk, and
// that the other channel registers and all setup banks live elsewhere.
`timescale 1ns/1ps
`include "csr_defines.vh"

module csr_channel_regs #(
	parameter NUM_CH       = 16,
	parameter CH_BITS      = 4,
	parameter NUM_SETUPS   = 8,
	parameter SETUP_BITS   = 3,
	parameter INPUT_BITS   = 10,
	parameter CFG_WIDTH    = 16,
	parameter COEF_WIDTH   = 24,
	// Arbitrary neutral identity value.
	parameter [15:0] PRODUCT_IDENTITY = `CSR_IDENTITY_DEFAULT
) (
	// Clock and reset
	input  wire                                clk,
	input  wire                                rst_n,
	// Register port
	input  wire [7:0]                          regAddr,
	input  wire [15:0]                         regWrData,
	input  wire                                regWrStrobe,
	input  wire                                regRdStrobe,
	output reg  [15:0]                         regRdData,
	output reg                                 regRdValid,
	// Channel zero fields for the rest of the converter
	output wire                                firstChannelEnable,
	output wire [SETUP_BITS-1:0]               firstChannelSetupChoice,
	output wire [INPUT_BITS-1:0]               firstChannelInputPair,
	// Remaining channel registers, channel 1 in the lowest slice
	input  wire [NUM_CH-1:1]                   otherChanEnable,
	input  wire [(NUM_CH-1)*SETUP_BITS-1:0]    otherChanSetup,
	input  wire [(NUM_CH-1)*INPUT_BITS-1:0]    otherChanInput,
	// Setup banks, setup 0 in the lowest slice
	input  wire [NUM_SETUPS*CFG_WIDTH-1:0]     setupConfigBank,
	input  wire [NUM_SETUPS*CFG_WIDTH-1:0]     filterConfigBank,
	input  wire [NUM_SETUPS*COEF_WIDTH-1:0]    offsetBank,
	input  wire [NUM_SETUPS*COEF_WIDTH-1:0]    gainBank,
	// Conversion events from the modulator and filter
	input  wire                                conversionDone,
	// Configuration applied to the modulator
	output reg  [CH_BITS-1:0]                  activeChannel,
	output reg                                 convertingValid,
	output reg                                 conversionStart,
	output reg  [INPUT_BITS-1:0]               activeInputPair,
	output reg  [SETUP_BITS-1:0]               activeSetup,
	output reg  [CFG_WIDTH-1:0]                activeSetupConfig,
	output reg  [CFG_WIDTH-1:0]                activeFilterConfig,
	output reg  [COEF_WIDTH-1:0]               activeOffset,
	output reg  [COEF_WIDTH-1:0]               activeGain
);

	// ----------------------------------------------------------------
	// Channel zero register
	// ----------------------------------------------------------------
	reg  [15:0] channelZeroConfig;
	wire        hitChanZero;
	wire        hitIdentity;
	wire        hitStatus;

	assign hitChanZero = (regAddr == `CSR_ADDR_CHAN_ZERO);
	assign hitIdentity = (regAddr == `CSR_ADDR_IDENTITY);
	assign hitStatus   = (regAddr == `CSR_ADDR_SEQ_STATUS);

	// Writes to the identity and status offsets fall through with no effect.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			channelZeroConfig <= `CSR_CH_ZERO_RESET;
		end else if (regWrStrobe && hitChanZero) begin
			channelZeroConfig <= regWrData & `CSR_CH_WRITE_MASK;
		end
	end

	assign firstChannelEnable      = channelZeroConfig[`CSR_CH_ENABLE_BIT];
	assign firstChannelSetupChoice = channelZeroConfig[`CSR_CH_SETUP_MSB:`CSR_CH_SETUP_LSB];
	assign firstChannelInputPair   = channelZeroConfig[`CSR_CH_INPUT_MSB:`CSR_CH_INPUT_LSB];

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	wire [NUM_CH-1:0]            allEnable;
	wire [NUM_CH*SETUP_BITS-1:0] allSetup;
	wire [NUM_CH*INPUT_BITS-1:0] allInput;
	wire [CH_BITS-1:0]           seqChannel;
	wire                         seqRunning;
	wire                         seqSwitched;

	assign allEnable = {otherChanEnable, firstChannelEnable};
	assign allSetup  = {otherChanSetup, firstChannelSetupChoice};
	assign allInput  = {otherChanInput, firstChannelInputPair};

	csr_sequencer #(
		.NUM_CH  (NUM_CH),
		.CH_BITS (CH_BITS)
	) sequencer (
		.clk            (clk),
		.rst_n          (rst_n),
		.chanEnable     (allEnable),
		.conversionDone (conversionDone),
		.activeChannel  (seqChannel),
		.running        (seqRunning),
		.switched       (seqSwitched)
	);

	// ----------------------------------------------------------------
	// Setup selection
	// ----------------------------------------------------------------
	// Every channel shares one setup when software wrote the same code into
	// each enabled register; nothing here checks or enforces that.
	wire [SETUP_BITS-1:0] next_setup;
	wire [INPUT_BITS-1:0] next_input;

	assign next_setup = allSetup[seqChannel*SETUP_BITS +: SETUP_BITS];
	assign next_input = allInput[seqChannel*INPUT_BITS +: INPUT_BITS];

	// All four setup words are taken from one index in one edge, so the
	// modulator never sees a mix of two setups.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			activeChannel      <= {CH_BITS{1'b0}};
			convertingValid    <= 1'b0;
			conversionStart    <= 1'b0;
			activeInputPair    <= {INPUT_BITS{1'b0}};
			activeSetup        <= {SETUP_BITS{1'b0}};
			activeSetupConfig  <= {CFG_WIDTH{1'b0}};
			activeFilterConfig <= {CFG_WIDTH{1'b0}};
			activeOffset       <= {COEF_WIDTH{1'b0}};
			activeGain         <= {COEF_WIDTH{1'b0}};
		end else begin
			activeChannel      <= seqChannel;
			convertingValid    <= seqRunning;
			conversionStart    <= seqSwitched;
			activeInputPair    <= next_input;
			activeSetup        <= next_setup;
			activeSetupConfig  <= setupConfigBank[next_setup*CFG_WIDTH +: CFG_WIDTH];
			activeFilterConfig <= filterConfigBank[next_setup*CFG_WIDTH +: CFG_WIDTH];
			activeOffset       <= offsetBank[next_setup*COEF_WIDTH +: COEF_WIDTH];
			activeGain         <= gainBank[next_setup*COEF_WIDTH +: COEF_WIDTH];
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	reg [15:0] next_rdData;
	reg [15:0] statusWord;

	always @* begin
		statusWord = 16'h0000;
		statusWord[`CSR_ST_RUNNING_BIT] = convertingValid;
		statusWord[`CSR_ST_SETUP_MSB:`CSR_ST_SETUP_LSB] = activeSetup;
		statusWord[`CSR_ST_CHAN_LSB +: CH_BITS] = activeChannel;
	end

	// Unmapped offsets read as zero.
	always @* begin
		next_rdData = 16'h0000;
		if (hitIdentity) begin
			next_rdData = PRODUCT_IDENTITY;
		end else if (hitChanZero) begin
			next_rdData = channelZeroConfig & `CSR_CH_WRITE_MASK;
		end else if (hitStatus) begin
			next_rdData = statusWord;
		end
	end

	// Read data stand for exactly the cycle after the strobe.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData  <= 16'h0000;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRdStrobe;
			if (regRdStrobe) begin
				regRdData <= next_rdData;
			end else begin
				regRdData <= 16'h0000;
			end
		end
	end

endmodule

// >>> verification/csr_channel_regs_asserts.sv
// Checker for the channel setup register block, bound to its top module.
// Assumes the default parameter widths of the top module.
`timescale 1ns/1ps
`include "csr_defines.vh"

module csr_channel_regs_asserts (
	// Clock and reset
	input wire logic         clk,
	input wire logic         rst_n,
	// Register port
	input wire logic [7:0]   regAddr,
	input wire logic [15:0]  regWrData,
	input wire logic         regWrStrobe,
	input wire logic         regRdStrobe,
	input wire logic [15:0]  regRdData,
	input wire logic         regRdValid,
	// Channel zero fields
	input wire logic         firstChannelEnable,
	input wire logic [2:0]   firstChannelSetupChoice,
	input wire logic [9:0]   firstChannelInputPair,
	// Setup banks and conversion
	input wire logic [127:0] setupConfigBank,
	input wire logic [127:0] filterConfigBank,
	input wire logic [191:0] offsetBank,
	input wire logic [191:0] gainBank,
	input wire logic         conversionDone,
	input wire logic [3:0]   activeChannel,
	input wire logic         convertingValid,
	input wire logic         conversionStart,
	input wire logic [9:0]   activeInputPair,
	input wire logic [2:0]   activeSetup,
	input wire logic [15:0]  activeSetupConfig,
	input wire logic [15:0]  activeFilterConfig,
	input wire logic [23:0]  activeOffset,
	input wire logic [23:0]  activeGain
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_wrChan; regWrStrobe && regAddr == `CSR_ADDR_CHAN_ZERO; endsequence
	sequence s_rdChan; regRdStrobe && regAddr == `CSR_ADDR_CHAN_ZERO; endsequence
	sequence s_doneRun; conversionDone && convertingValid; endsequence

	property p_idRead;
		regRdStrobe && regAddr == `CSR_ADDR_IDENTITY |=> regRdValid && regRdData == `CSR_IDENTITY_DEFAULT;
	endproperty
	property p_resetVal;
		disable iff (1'b0) !rst_n |-> firstChannelEnable && firstChannelSetupChoice == 3'h0
			&& firstChannelInputPair == 10'h001;
	endproperty
	property p_enWrite; s_wrChan |=> firstChannelEnable == $past(regWrData[15]); endproperty
	property p_seqStep; s_doneRun |-> ##2 conversionStart; endproperty
	property p_setupPick;
		conversionStart && activeChannel == 4'h0 |-> activeSetup == firstChannelSetupChoice
			&& activeInputPair == firstChannelInputPair;
	endproperty
	property p_bankApply;
		conversionStart |-> activeSetupConfig == setupConfigBank[activeSetup*16 +: 16]
			&& activeFilterConfig == filterConfigBank[activeSetup*16 +: 16]
			&& activeOffset == offsetBank[activeSetup*24 +: 24] && activeGain == gainBank[activeSetup*24 +: 24];
	endproperty
	property p_inWrite; s_wrChan |=> firstChannelInputPair == $past(regWrData[9:0]); endproperty
	property p_chanRead;
		s_rdChan |=> regRdValid && regRdData == {firstChannelEnable, firstChannelSetupChoice, 2'b00,
			firstChannelInputPair};
	endproperty

	a_idRead:    assert property (p_idRead) else $error("identity read wrong");
	a_resetVal:  assert property (p_resetVal) else $error("channel reset value wrong");
	a_enWrite:   assert property (p_enWrite) else $error("enable not written");
	a_seqStep:   assert property (p_seqStep) else $error("no step after done");
	a_setupPick: assert property (p_setupPick) else $error("setup choice not used");
	a_bankApply: assert property (p_bankApply) else $error("setup bank mismatch");
	a_inWrite:   assert property (p_inWrite) else $error("input pair not written");
	a_chanRead:  assert property (p_chanRead) else $error("channel readback wrong");
endmodule

bind csr_channel_regs csr_channel_regs_asserts u_chk (.*);

// >>> verification/csr_channel_regs_test.sv
// Self-checking bench for the channel setup register block.
// Assumes default parameters and a one-cycle read latency.
`timescale 1ns/1ps

module csr_channel_regs_test;
	logic         clk = 0, rst_n = 1, regWrStrobe = 0, regRdStrobe = 0, conversionDone = 0;
	logic [7:0]   regAddr = 0;
	logic [15:0]  regWrData = 0, regRdData;
	logic         regRdValid, firstChannelEnable, convertingValid, conversionStart;
	logic [2:0]   firstChannelSetupChoice, activeSetup;
	logic [9:0]   firstChannelInputPair, activeInputPair;
	logic [15:1]  otherChanEnable = 0;
	logic [44:0]  otherChanSetup = 45'h0;
	logic [149:0] otherChanInput = 150'h0;
	logic [127:0] setupConfigBank, filterConfigBank;
	logic [191:0] offsetBank, gainBank;
	logic [3:0]   activeChannel;
	logic [15:0]  activeSetupConfig, activeFilterConfig;
	logic [23:0]  activeOffset, activeGain;
	int           n_errors = 0, cmp_count = 0, cyc = 0;

	csr_channel_regs dut (.*);

	always #4 clk = ~clk;

	// Bounded run: a hang counts as a mismatch.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regWrStrobe <= 1; regAddr <= a; regWrData <= d;
		@(posedge clk);
		regWrStrobe <= 0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		regRdStrobe <= 1; regAddr <= a;
		@(posedge clk);
		regRdStrobe <= 0;
		#1 chk({regRdValid, 7'h00, regRdData}, {1'b1, 7'h00, exp});
	endtask

	// One edge after the taking edge the new conversion is shown.
	task automatic done();
		@(posedge clk);
		conversionDone <= 1;
		@(posedge clk);
		conversionDone <= 0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		// Reset starts high and falls at once, so the asynchronous reset sees an edge.
		rst_n <= 0;
		for (int k = 0; k < 8; k++) begin
			setupConfigBank[k*16 +: 16] = 16'h1000 + k;
			filterConfigBank[k*16 +: 16] = 16'h2000 + k;
			offsetBank[k*24 +: 24] = 24'h30_0000 + k;
			gainBank[k*24 +: 24] = 24'h40_0000 + k;
		end
		otherChanSetup[8:6] = 3'h5;
		otherChanInput[29:20] = 10'h123;
		repeat (10) @(posedge clk);
		rst_n <= 1;
		rd(8'h10, 16'h8001);
		rd(8'h07, 16'h5A5A);
		wr(8'h07, 16'h0000);
		rd(8'h07, 16'h5A5A);
		rd(8'h33, 16'h0000);
		wr(8'h10, 16'hFFFF);
		rd(8'h10, 16'hF3FF);
		$display("test registers done");
		for (int s = 0; s < 8; s++) begin
			wr(8'h10, 16'h802A | (s << 12));
			rd(8'h10, 16'h802A | (s << 12));
			done();
			chk(activeSetup, s);
			chk(activeFilterConfig, 16'h2000 + s);
			chk(activeGain, 24'h40_0000 + s);
			chk(activeInputPair, 10'h02A);
		end
		$display("test setups done");
		@(posedge clk);
		otherChanEnable <= 15'h0004;
		done();
		chk(activeChannel, 4'h3);
		chk({activeSetup, activeInputPair}, {3'h5, 10'h123});
		done();
		chk(activeChannel, 4'h0);
		// Shared setup: channel zero is given the same code as channel three.
		wr(8'h10, 16'hD02A);
		done();
		chk({activeChannel, activeSetup}, {4'h3, 3'h5});
		done();
		chk({activeChannel, activeSetup}, {4'h0, 3'h5});
		rd(8'h7F, 16'hD000);
		@(posedge clk);
		otherChanEnable <= 15'h0000;
		wr(8'h10, 16'h0001);
		repeat (4) @(posedge clk);
		#1 chk(convertingValid, 1'b0);
		$display("test sequencing done");
		end_of_test();
	end
endmodule
